// *** common/dpt_defs.svh ***
// constants of the discoverable parameter table read path
// assumes one clock domain; included by name from the modules
`ifndef DPT_DEFS_SVH
`define DPT_DEFS_SVH

// ----------------------------------------------------------------------
// command framing
// ----------------------------------------------------------------------
`define DPT_CMD_READ        8'h5A
`define DPT_BYTE_LAST       5'h07
`define DPT_ADDR_LAST       5'h17
`define DPT_DUMMY_LAST      5'h07

// ----------------------------------------------------------------------
// header contents
// ----------------------------------------------------------------------
`define DPT_SIG_S           8'h53
`define DPT_SIG_F           8'h46
`define DPT_SIG_D           8'h44
`define DPT_SIG_P           8'h50
`define DPT_REV_MINOR       8'h06
`define DPT_REV_MAJOR       8'h01
`define DPT_NUM_HDRS        8'h01
`define DPT_FILL            8'hFF
`define DPT_ID_BASIC        8'h00
`define DPT_ID_4BAI         8'h84
`define DPT_REV_4BAI_MINOR  8'h00
`define DPT_LEN_BASIC       8'h10
`define DPT_LEN_4BAI        8'h02
`define DPT_PTR_BASIC       24'h00_0300
`define DPT_PTR_4BAI        24'h00_0340
`define DPT_HDR_BYTES       24'h00_0018

`endif

// *** common/dpt_pkg.sv ***
// types of the discoverable parameter table read path
// assumes dpt_defs.svh sits beside it
package dpt_pkg;

  // gray along idle, command, address, dummy, data
  typedef enum logic [2:0] {
    DPT_IDLE   = 3'h0,
    DPT_CMD    = 3'h1,
    DPT_ADDR   = 3'h3,
    DPT_DUMMY  = 3'h2,
    DPT_DATA   = 3'h6,
    DPT_IGNORE = 3'h7
  } dpt_state_t;

endpackage : dpt_pkg

// *** rtl/dpt_sfdp_read.sv ***
// serial read port of the discoverable parameter space, mode 0 framing
// assumes pins arrive synchronous to clk and sclk runs no faster than clk / 2
//
// Summary of operation
// - Instruction 5Ah returns bytes from a space apart from the main array.
// - The space starts with its header at byte address zero, the entry point.
// - Bytes 00h to 03h hold signature 53h, 46h, 44h, 50h.
// - Header gives format revision plus revision and pointer for each table.
// - First parameter table starts at 0300h; bytes before it are undefined.
// - Space after header and after tables is undefined; host must not rely.
// - Physical order: header, basic flash table, then four-byte-address table.
// - Space is factory fixed and read-only; writes or erases change nothing.
// - Byte 04h minor revision 06h, byte 05h major revision 01h.
// - Byte 06h header count zero based, 01h; byte 07h reads FFh.
// - Headers give length in dwords, basic 10h, then an aligned pointer.
`timescale 1ns/100ps
`include "dpt_defs.svh"

module dpt_sfdp_read (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // serial pins
  input  wire logic csN,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso,
  output logic      misoEnN,
  // status
  output logic      readActive
);

  localparam logic [23:0] PtrBasic = `DPT_PTR_BASIC;
  localparam logic [23:0] Ptr4b    = `DPT_PTR_4BAI;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  dpt_pkg::dpt_state_t stateQ;
  dpt_pkg::dpt_state_t stateD;
  logic        sclkQ;
  logic [4:0]  cntQ;
  logic [4:0]  cntD;
  logic [7:0]  cmdQ;
  logic [7:0]  cmdD;
  logic [7:0]  cmdIn;
  logic [23:0] addrQ;
  logic [23:0] addrD;
  logic [7:0]  outQ;
  logic [7:0]  outD;
  logic        soQ;
  logic        soD;
  logic        sclkRise;
  logic        sclkFall;
  logic [7:0]  romData;

  dpt_table_rom uRom (
    .romAddr (addrQ),
    .romData (romData)
  );

  assign sclkRise   = sclk & ~sclkQ;
  assign sclkFall   = ~sclk & sclkQ;
  assign miso       = soQ;
  assign misoEnN    = ~((stateQ == dpt_pkg::DPT_DATA) & ~csN);
  assign readActive = (stateQ == dpt_pkg::DPT_DATA);

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // sampling on rising sclk and shifting on falling sclk gives the host a
  // half serial period of setup on miso
  always_comb begin
    stateD = stateQ;
    cntD   = cntQ;
    cmdD   = cmdQ;
    addrD  = addrQ;
    outD   = outQ;
    soD    = soQ;
    cmdIn  = {cmdQ[6:0], mosi};
    if (csN) begin
      stateD = dpt_pkg::DPT_IDLE;
      cntD   = 5'h00;
    end else begin
      case (stateQ)
        dpt_pkg::DPT_IDLE: begin
          stateD = dpt_pkg::DPT_CMD;
          cntD   = 5'h00;
        end
        dpt_pkg::DPT_CMD: begin
          if (sclkRise) begin
            cmdD = cmdIn;
            cntD = cntQ + 5'h01;
            if (cntQ == `DPT_BYTE_LAST) begin
              cntD = 5'h00;
              // anything else, program and erase included, is ignored
              if (cmdIn == `DPT_CMD_READ) begin
                stateD = dpt_pkg::DPT_ADDR;
              end else begin
                stateD = dpt_pkg::DPT_IGNORE;
              end
            end
          end
        end
        dpt_pkg::DPT_ADDR: begin
          if (sclkRise) begin
            addrD = {addrQ[22:0], mosi};
            cntD  = cntQ + 5'h01;
            if (cntQ == `DPT_ADDR_LAST) begin
              cntD   = 5'h00;
              stateD = dpt_pkg::DPT_DUMMY;
            end
          end
        end
        dpt_pkg::DPT_DUMMY: begin
          if (sclkRise) begin
            cntD = cntQ + 5'h01;
            if (cntQ == `DPT_DUMMY_LAST) begin
              cntD   = 5'h00;
              stateD = dpt_pkg::DPT_DATA;
            end
          end
        end
        dpt_pkg::DPT_DATA: begin
          if (sclkFall) begin
            if (cntQ == 5'h00) begin
              // fetch and advance; the 24-bit address wraps at the top
              soD   = romData[7];
              outD  = {romData[6:0], 1'b0};
              addrD = addrQ + 24'h00_0001;
            end else begin
              soD  = outQ[7];
              outD = {outQ[6:0], 1'b0};
            end
            cntD = (cntQ == `DPT_BYTE_LAST) ? 5'h00 : cntQ + 5'h01;
          end
        end
        dpt_pkg::DPT_IGNORE: begin
          stateD = dpt_pkg::DPT_IGNORE;
        end
        default: begin
          stateD = dpt_pkg::DPT_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stateQ <= dpt_pkg::DPT_IDLE;
      sclkQ  <= 1'b0;
      cntQ   <= 5'h00;
      cmdQ   <= 8'h00;
      addrQ  <= 24'h00_0000;
      outQ   <= 8'h00;
      soQ    <= 1'b0;
    end else begin
      stateQ <= stateD;
      sclkQ  <= sclk;
      cntQ   <= cntD;
      cmdQ   <= cmdD;
      addrQ  <= addrD;
      outQ   <= outD;
      soQ    <= soD;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  AST_CMD_GATE: assert property (
    (stateQ == dpt_pkg::DPT_ADDR && $past(stateQ) == dpt_pkg::DPT_CMD)
      |-> cmdQ == `DPT_CMD_READ)
    else $error("address phase entered without the read instruction");

  AST_ENTRY: assert property (
    (stateQ == dpt_pkg::DPT_DATA && !csN && sclkFall && cntQ == 5'h00
      && addrQ == 24'h00_0000)
      |=> (soQ == 1'b0) && (outQ == 8'hA6) && (addrQ == 24'h00_0001))
    else $error("entry byte at address zero not shifted out");

  AST_SIG: assert property (
    (addrQ[23:2] == 22'h00_0000) |-> romData ==
      ((addrQ[1:0] == 2'h0) ? `DPT_SIG_S : (addrQ[1:0] == 2'h1) ? `DPT_SIG_F :
       (addrQ[1:0] == 2'h2) ? `DPT_SIG_D : `DPT_SIG_P))
    else $error("signature byte wrong");

  AST_HDR4: assert property (
    (addrQ == 24'h00_0010) |-> romData == `DPT_ID_4BAI)
    else $error("second parameter header missing");

  AST_UNDEF: assert property (
    (addrQ >= `DPT_HDR_BYTES && addrQ < PtrBasic) |-> romData == `DPT_FILL)
    else $error("gap before first table not fill");

  // the address moves once per byte, so length and pointer get a check each
  AST_PTR: assert property (
    (addrQ == 24'h00_000D) |-> romData == PtrBasic[15:8])
    else $error("basic table pointer wrong");

  AST_LEN: assert property (
    (addrQ == 24'h00_000B) |-> romData == `DPT_LEN_BASIC)
    else $error("basic table length wrong");

  AST_ORDER: assert property (
    (addrQ == 24'h00_0014) |-> romData == Ptr4b[7:0] && Ptr4b > PtrBasic)
    else $error("table order broken");

  AST_REV: assert property (
    (addrQ == 24'h00_0004) |=> (addrQ == 24'h00_0005) |-> romData == `DPT_REV_MAJOR
      && $past(romData) == `DPT_REV_MINOR)
    else $error("header revision wrong");

  AST_NPH: assert property (
    (addrQ[23:1] == 23'h00_0003) |-> romData ==
      (addrQ[0] ? `DPT_FILL : `DPT_NUM_HDRS))
    else $error("header count or unused byte wrong");

  AST_RO: assert property (
    (stateQ == dpt_pkg::DPT_IGNORE) |-> misoEnN && !readActive && $stable(addrQ))
    else $error("refused instruction reached the parameter space");

  AST_EN: assert property (
    (!misoEnN && !$past(readActive)) |-> ($past(stateQ) == dpt_pkg::DPT_DUMMY)
      && ($past(cntQ) == `DPT_DUMMY_LAST))
    else $error("output enabled without a full read preamble");

  COV_READ: cover property (
    stateQ == dpt_pkg::DPT_DUMMY ##1 stateQ == dpt_pkg::DPT_DATA);
  COV_IGNORE: cover property (stateQ == dpt_pkg::DPT_IGNORE);
  COV_SECOND: cover property (
    stateQ == dpt_pkg::DPT_DATA && addrQ == 24'h00_0002);
  COV_ABORT: cover property (
    stateQ == dpt_pkg::DPT_DATA && cntQ == 5'h03 ##1 stateQ == dpt_pkg::DPT_IDLE);

endmodule : dpt_sfdp_read

// *** rtl/dpt_table_rom.sv ***
// read-only byte image of the discoverable parameter space
// assumes a combinational lookup; the caller registers the result
`timescale 1ns/100ps
`include "dpt_defs.svh"

module dpt_table_rom (
  // lookup
  input  wire logic [23:0] romAddr,
  output logic      [7:0]  romData
);

  localparam logic [23:0] PtrBasic = `DPT_PTR_BASIC;
  localparam logic [23:0] Ptr4b    = `DPT_PTR_4BAI;

  // ----------------------------------------------------------------------
  // header image: signature, revisions, two parameter headers
  // ----------------------------------------------------------------------
  // constant array only: nothing here can be written, so no command alters it
  localparam logic [7:0] Hdr [0:23] = '{
    `DPT_SIG_S, `DPT_SIG_F, `DPT_SIG_D, `DPT_SIG_P,
    `DPT_REV_MINOR, `DPT_REV_MAJOR, `DPT_NUM_HDRS, `DPT_FILL,
    `DPT_ID_BASIC, `DPT_REV_MINOR, `DPT_REV_MAJOR, `DPT_LEN_BASIC,
    PtrBasic[7:0], PtrBasic[15:8], PtrBasic[23:16], `DPT_FILL,
    `DPT_ID_4BAI, `DPT_REV_4BAI_MINOR, `DPT_REV_MAJOR, `DPT_LEN_4BAI,
    Ptr4b[7:0], Ptr4b[15:8], Ptr4b[23:16], `DPT_FILL
  };

  // table bodies are not carried here; they read as fill like undefined space
  always_comb begin
    if (romAddr < `DPT_HDR_BYTES) begin
      romData = Hdr[romAddr[4:0]];
    end else begin
      romData = `DPT_FILL;
    end
  end

endmodule : dpt_table_rom

// *** testbench/dpt_host_model.sv ***
// serial host that frames reads of the parameter space, mode 0
// assumes the bench drives nothing on csN, sclk or mosi itself
`timescale 1ns/100ps

module dpt_host_model (
  // clock
  input  wire logic clk,
  // serial pins
  output logic      csN,
  output logic      sclk,
  output logic      mosi,
  input  wire logic miso,
  input  wire logic misoEnN,
  input  wire logic readActive
);
  logic [7:0] rxByte [0:31];
  int         enLow;

  initial begin
    csN  = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // each sclk level lasts two clk periods, twice the shortest the port allows
  task automatic half2();
    repeat (2) @(negedge clk);
  endtask : half2

  // instruction, address, eight dummies, then nBits of data; a partial byte aborts
  task automatic frame(input logic [7:0] cmd, input logic [23:0] addr, input int nBits);
    logic [31:0] head;
    head  = {cmd, addr};
    enLow = 0;
    @(negedge clk);
    csN = 1'b0;
    half2();
    for (int i = 0; i < 40 + nBits; i++) begin
      sclk = 1'b0;
      // dummies and data time carry noise so a stale level is never mistaken
      mosi = (i < 32) ? head[31-i] : 1'($urandom);
      half2();
      if (i >= 40) begin
        rxByte[(i-40)/8][7-(i-40)%8] = miso;
        if (misoEnN === 1'b0 && readActive === 1'b1) enLow++;
      end
      sclk = 1'b1;
      half2();
    end
    sclk = 1'b0;
    half2();
    csN  = 1'b1;
    mosi = ~mosi;
    half2();
  endtask : frame
endmodule : dpt_host_model

// *** testbench/test_discoverable_param_table_read.sv ***
// self-checking bench of the parameter space read port
// assumes the host model frames every transfer; expectations come from the header image
`timescale 1ns/100ps

module test_discoverable_param_table_read;
  localparam logic [191:0] HDR = 192'h5346_4450_0601_01FF_0006_0110_0003_00FF_8400_0102_4003_00FF;
  logic        clk;
  logic        sys_rst;
  logic        csN;
  logic        sclk;
  logic        mosi;
  logic        miso;
  logic        misoEnN;
  logic        readActive;
  int          n_fail;
  int          n_compared;
  int          cycles;
  logic [23:0] addr;
  logic [23:0] ptrBasic;
  logic [23:0] ptrWide;
  logic [7:0]  refused [0:6];

  dpt_sfdp_read DUT (.clk(clk), .sys_rst(sys_rst), .csN(csN), .sclk(sclk), .mosi(mosi),
                     .miso(miso), .misoEnN(misoEnN), .readActive(readActive));
  dpt_host_model host (.clk(clk), .csN(csN), .sclk(sclk), .mosi(mosi), .miso(miso),
                       .misoEnN(misoEnN), .readActive(readActive));

  initial clk = 1'b0;
  always #4 clk = ~clk;

  // ------------------------------------------------------------
  // expectations and compares
  // ------------------------------------------------------------
  // bytes past the header, table bodies included, read as erased
  function automatic logic [7:0] expByte(input logic [23:0] a);
    return (a < 24'h00_0018) ? HDR[191 - 8 * a[4:0] -: 8] : 8'hFF;
  endfunction : expByte

  task automatic checkByte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkByte

  task automatic checkCount(input int got, input int exp);
    n_compared++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : checkCount

  task automatic readCheck(input logic [7:0] cmd, input logic [23:0] a, input int n);
    host.frame(cmd, a, n * 8);
    for (int k = 0; k < n && cmd == 8'h5A; k++) begin
      checkByte(host.rxByte[k], expByte(a + 24'(k)));
    end
    checkCount(host.enLow, (cmd == 8'h5A) ? n * 8 : 0);
    checkByte({7'h00, misoEnN}, 8'h01);
    checkByte({7'h00, readActive}, 8'h00);
  endtask : readCheck

  task automatic report_and_stop();
    $display("compares %0d, mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : report_and_stop

  // a frame costs under 1300 cycles; the run holds twenty-four of them
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    sys_rst    = 1'b1;
    n_fail     = 0;
    n_compared = 0;
    cycles     = 0;
    refused    = '{8'h03, 8'h0B, 8'h02, 8'h20, 8'hD8, 8'hC7, 8'h06};
    addr       = 24'($urandom(32'h0000_415c));
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    readCheck(8'h5A, 24'h00_0000, 24);
    ptrBasic = {host.rxByte[14], host.rxByte[13], host.rxByte[12]};
    ptrWide  = {host.rxByte[22], host.rxByte[21], host.rxByte[20]};
    checkCount(int'(ptrBasic), 32'h0000_0300);
    checkCount(int'(ptrWide > ptrBasic), 1);
    readCheck(8'h5A, ptrBasic - 24'h00_0001, 2);
    readCheck(8'h5A, 24'h00_0005, 3);
    readCheck(8'h5A, 24'hFF_FFFF, 3);
    // other read, program, erase and write-enable codes must neither answer nor change the image
    foreach (refused[i]) begin
      readCheck(refused[i], 24'h00_0000, 2);
    end
    readCheck(8'h5A, 24'h00_0000, 8);
    // cut two bits into the second byte; the next frame must start clean
    host.frame(8'h5A, 24'h00_0000, 10);
    checkByte(host.rxByte[0], expByte(24'h00_0000));
    checkByte({7'h00, misoEnN}, 8'h01);
    readCheck(8'h5A, 24'h00_0010, 8);
    for (int r = 0; r < 10; r++) begin
      addr = ($urandom % 3 == 0) ? 24'($urandom) : 24'($urandom_range(0, 40));
      readCheck(8'h5A, addr, $urandom_range(1, 6));
    end
    report_and_stop();
  end
endmodule : test_discoverable_param_table_read
